//--- dv/mdss_chk.sv
// checker: movx steering assertions on the selector's ports
`timescale 1ns/1ps
`default_nettype none
module mdss_chk import mdss_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // core and far-side inputs
  input wire mdss_movx_req_t i_movx,
  input wire logic [7:0] i_nvm_rdata,
  input wire logic i_nvm_busy,
  input wire logic [7:0] i_ext_rdata,
  // steering outputs
  input wire logic [7:0] o_movx_rdata,
  input wire logic o_movx_rvalid,
  input wire logic o_movx_rdata_bad,
  input wire logic o_nvm_rd,
  input wire logic o_ext_rd,
  input wire logic o_ext_wr,
  input wire logic [7:0] o_nvm_control
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic en;
  logic lo;
  // nvm read enable and the inclusive low window
  assign en = o_nvm_control[MDSS_NVM_READ_ENABLE_BIT];
  assign lo = i_movx.addr <= MDSS_WINDOW_LAST;
  sequence s_rd; i_movx.valid && !i_movx.write && en; endsequence
  sequence s_wr; i_movx.valid && i_movx.write && en; endsequence
  property p_nvm_lo; s_rd ##0 lo |-> o_nvm_rd && !o_ext_rd; endproperty
  a_nvm_lo: assert property (p_nvm_lo) else $error("nvm read missing");
  property p_dp_hi; s_rd ##0 (!lo && i_movx.dptr_mode) |-> o_ext_rd && !o_nvm_rd; endproperty
  a_dp_hi: assert property (p_dp_hi) else $error("dptr read not external");
  property p_r_hi; s_rd ##0 (!lo && !i_movx.dptr_mode) |-> !o_ext_rd ##1 !o_movx_rvalid; endproperty
  a_r_hi: assert property (p_r_hi) else $error("r0 r1 read above window served");
  property p_wr_lo; s_wr ##0 lo |-> !o_ext_wr && !o_nvm_rd; endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("low write not ignored");
  property p_wr_hi; s_wr ##0 (!lo && i_movx.dptr_mode) |-> o_ext_wr; endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("dptr write not external");
  property p_r_wr; s_wr ##0 !i_movx.dptr_mode |-> !o_ext_wr ##1 !o_movx_rvalid; endproperty
  a_r_wr: assert property (p_r_wr) else $error("r0 r1 write had effect");
  property p_nvm_d; o_nvm_rd |=> o_movx_rvalid && o_movx_rdata == $past(i_nvm_rdata); endproperty
  a_nvm_d: assert property (p_nvm_d) else $error("nvm data not returned");
  property p_ext_d; o_ext_rd |=> o_movx_rvalid && o_movx_rdata == $past(i_ext_rdata); endproperty
  a_ext_d: assert property (p_ext_d) else $error("external data not returned");
  property p_bad; o_nvm_rd && i_nvm_busy && |o_nvm_control[7:6] |=> o_movx_rdata_bad; endproperty
  a_bad: assert property (p_bad) else $error("busy nvm read not flagged");
  property p_rst; $rose(i_arst_n) |-> o_nvm_control == MDSS_REG_RESET; endproperty
  a_rst: assert property (p_rst) else $error("control not cleared by reset");
endmodule : mdss_chk
bind mdss_top mdss_chk mdss_chk_i (.i_clk, .i_arst_n, .i_movx, .i_nvm_rdata, .i_nvm_busy,
  .i_ext_rdata, .o_movx_rdata, .o_movx_rvalid, .o_movx_rdata_bad, .o_nvm_rd, .o_ext_rd,
  .o_ext_wr, .o_nvm_control);
`default_nettype wire

//--- dv/mdss_far_model.sv
// far-side model: address-derived read data standing in for nvm and external data memory
`timescale 1ns/1ps
`default_nettype none
module mdss_far_model (
  // nvm side
  input wire logic [10:0] i_nvm_addr,
  output logic [7:0] o_nvm_rdata,
  // external bus side
  input wire logic [15:0] i_ext_addr,
  output logic [7:0] o_ext_rdata
);
  // address patterns so locations within one 256-byte page read distinct
  assign o_nvm_rdata = i_nvm_addr[7:0] ^ 8'ha5;
  assign o_ext_rdata = i_ext_addr[7:0] + i_ext_addr[15:8];
endmodule : mdss_far_model
`default_nettype wire

//--- dv/tb_top.sv
// testbench: sfr and movx sequences against the data-space selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top import mdss_pkg::*; ;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_nvm_busy = 1'b0;
  mdss_sfr_req_t i_sfr = '0;
  mdss_movx_req_t i_movx = '0;
  logic [7:0] o_sfr_rdata, o_movx_rdata, i_nvm_rdata, i_ext_rdata, o_ext_wdata;
  logic [7:0] o_nvm_control, o_nvm_data_port;
  logic o_sfr_hit, o_movx_rvalid, o_movx_rdata_bad, o_nvm_rd, o_ext_rd, o_ext_wr;
  logic [10:0] o_nvm_addr, o_nvm_prog_addr;
  logic [15:0] o_ext_addr;
  int n_mismatch = 0;
  int num_checks = 0;
  mdss_top mdss_top_i (.i_clk, .i_arst_n, .i_sfr, .o_sfr_rdata, .o_sfr_hit, .i_movx,
    .o_movx_rdata, .o_movx_rvalid, .o_movx_rdata_bad, .i_nvm_rdata, .i_nvm_busy, .o_nvm_rd,
    .o_nvm_addr, .o_ext_rd, .o_ext_wr, .o_ext_addr, .o_ext_wdata, .i_ext_rdata,
    .o_nvm_control, .o_nvm_data_port, .o_nvm_prog_addr);
  mdss_far_model mdss_far_model_i (.i_nvm_addr(o_nvm_addr), .o_nvm_rdata(i_nvm_rdata),
    .i_ext_addr(o_ext_addr), .o_ext_rdata(i_ext_rdata));
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  // one sfr write pulse
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) i_sfr <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk) i_sfr <= '0;
  endtask : sfr_wr
  // one sfr read pulse, data checked after the taking edge
  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e);
    logic hit;
    hit = a inside {MDSS_NVM_CONTROL_ADDR, MDSS_MEMORY_MODE_ADDR, MDSS_NVM_DATA_ADDR,
                    MDSS_NVM_ADDR_LOW_ADDR, MDSS_NVM_ADDR_HIGH_ADDR};
    @(posedge i_clk) i_sfr <= '{1'b0, 1'b1, a, 8'h00};
    #1 `CHK("sfr_hit", hit, o_sfr_hit)
    @(posedge i_clk) i_sfr <= '0;
    #1 `CHK("sfr_rdata", e, o_sfr_rdata)
  endtask : sfr_chk
  // one movx cycle: strobes {ext_rd, ext_wr, nvm_rd}, then {rvalid, bad} and data
  task automatic movx(input logic w, input logic dp, input logic [15:0] a,
      input logic [7:0] wd, input logic [2:0] es, input logic [1:0] er, input logic [7:0] ed);
    @(posedge i_clk) i_movx <= '{1'b1, w, dp, a, wd};
    #1 `CHK("strobes", es, {o_ext_rd, o_ext_wr, o_nvm_rd})
    `CHK("bus_copy", {a, wd, a[10:0]}, {o_ext_addr, o_ext_wdata, o_nvm_addr})
    @(posedge i_clk) i_movx <= '0;
    #1 `CHK("rvalid_bad", er, {o_movx_rvalid, o_movx_rdata_bad})
    if (er[1]) `CHK("movx_rdata", ed, o_movx_rdata)
  endtask : movx
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // watchdog well past the expected run
  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    sfr_chk(MDSS_NVM_CONTROL_ADDR, 8'h00);
    sfr_chk(MDSS_MEMORY_MODE_ADDR, 8'h00);
    sfr_chk(8'h80, 8'h00);
    movx(1'b0, 1'b1, 16'h0123, 8'h00, 3'b100, 2'b10, 8'h24);
    movx(1'b1, 1'b0, 16'h0040, 8'h11, 3'b010, 2'b00, 8'h00);
    $display("test reset and external done");
    sfr_wr(MDSS_MEMORY_MODE_ADDR, 8'h01);
    sfr_chk(MDSS_MEMORY_MODE_ADDR, 8'h01);
    movx(1'b1, 1'b1, 16'h07ff, 8'h3c, 3'b000, 2'b00, 8'h00);
    movx(1'b1, 1'b0, 16'h0000, 8'h5a, 3'b000, 2'b00, 8'h00);
    movx(1'b0, 1'b0, 16'h07ff, 8'h00, 3'b000, 2'b10, 8'h3c);
    movx(1'b0, 1'b1, 16'h0000, 8'h00, 3'b000, 2'b10, 8'h5a);
    $display("test aux sram done");
    sfr_wr(MDSS_NVM_CONTROL_ADDR, 8'h20);
    sfr_chk(MDSS_NVM_CONTROL_ADDR, 8'h20);
    movx(1'b0, 1'b1, 16'h0800, 8'h00, 3'b001, 2'b10, 8'ha5);
    movx(1'b0, 1'b1, 16'h0801, 8'h00, 3'b100, 2'b10, 8'h09);
    movx(1'b0, 1'b0, 16'h0010, 8'h00, 3'b001, 2'b10, 8'hb5);
    movx(1'b0, 1'b0, 16'h0801, 8'h00, 3'b000, 2'b00, 8'h00);
    movx(1'b1, 1'b1, 16'h0010, 8'h77, 3'b000, 2'b00, 8'h00);
    movx(1'b1, 1'b1, 16'h0900, 8'h77, 3'b010, 2'b00, 8'h00);
    movx(1'b1, 1'b0, 16'h0000, 8'h77, 3'b000, 2'b00, 8'h00);
    movx(1'b1, 1'b0, 16'h0900, 8'h77, 3'b000, 2'b00, 8'h00);
    $display("test nvm decode done");
    @(posedge i_clk) i_nvm_busy <= 1'b1;
    sfr_wr(MDSS_NVM_CONTROL_ADDR, 8'h60);
    movx(1'b0, 1'b1, 16'h0010, 8'h00, 3'b001, 2'b11, 8'hb5);
    sfr_wr(MDSS_NVM_CONTROL_ADDR, 8'h20);
    movx(1'b0, 1'b1, 16'h0010, 8'h00, 3'b001, 2'b10, 8'hb5);
    $display("test busy flag done");
    // clear the nvm enable before using aux again
    sfr_wr(MDSS_NVM_CONTROL_ADDR, 8'h00);
    movx(1'b0, 1'b0, 16'h0000, 8'h00, 3'b000, 2'b10, 8'h5a);
    sfr_wr(MDSS_NVM_DATA_ADDR, 8'hc3);
    sfr_chk(MDSS_NVM_DATA_ADDR, 8'hc3);
    $display("test aux kept done");
    sfr_wr(MDSS_NVM_ADDR_LOW_ADDR, 8'h34);
    sfr_wr(MDSS_NVM_ADDR_HIGH_ADDR, 8'hff);
    sfr_chk(MDSS_NVM_ADDR_HIGH_ADDR, 8'h07);
    `CHK("nvm_control", 8'h00, o_nvm_control)
    `CHK("nvm_copies", {8'hc3, 11'h734}, {o_nvm_data_port, o_nvm_prog_addr})
    $display("test register copies done");
    // second reset in mid-run with the aux enable set
    @(posedge i_clk) i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    sfr_chk(MDSS_MEMORY_MODE_ADDR, 8'h00);
    sfr_chk(MDSS_NVM_ADDR_HIGH_ADDR, 8'h00);
    movx(1'b0, 1'b1, 16'h0102, 8'h00, 3'b100, 2'b10, 8'h03);
    $display("test mid-run reset done");
    results();
  end
endmodule : tb_top
`default_nettype wire

//--- logic/mdss_pkg.sv
// package for the movx data-space selector: register map, fields, types
// Summary of operation
// [RULE_01] on-chip 2 KB auxiliary sram via movx
// [RULE_02] aux sram separate from 256-byte scratch-pad
// [RULE_03] aux_ram_enable set routes movx to sram
// [RULE_04] software clears nvm_read_enable when enabling sram
// [RULE_05] nvm_read_enable nvm_control.5, aux_ram_enable mode.0
// [RULE_06] nvm decodes at same addresses as sram
// [RULE_07] both enables clear: movx goes external
// [RULE_08] nvm off, aux on: sram serves movx
// [RULE_09] nvm enable: reads only, aux ignored
// [RULE_10] nvm read invalid while erase/write busy
// [RULE_11] dptr read: nvm up to 2K, external above
// [RULE_12] r0/r1 read: nvm up to 2K, nothing above
// [RULE_13] dptr write: ignored up to 2K, external above
// [RULE_14] r0/r1 write: no effect anywhere
// [RULE_15] both enables zero after reset
package mdss_pkg;
  // special function register offsets
  localparam logic [7:0] MDSS_NVM_CONTROL_ADDR = 8'h9E;
  localparam logic [7:0] MDSS_MEMORY_MODE_ADDR = 8'hC4;
  localparam logic [7:0] MDSS_NVM_DATA_ADDR = 8'hD3;
  localparam logic [7:0] MDSS_NVM_ADDR_LOW_ADDR = 8'hDB;
  localparam logic [7:0] MDSS_NVM_ADDR_HIGH_ADDR = 8'hEB;
  // field positions
  localparam int MDSS_NVM_READ_ENABLE_BIT = 5;
  localparam int MDSS_NVM_ERASE_REQ_BIT = 7;
  localparam int MDSS_NVM_WRITE_REQ_BIT = 6;
  localparam int MDSS_AUX_RAM_ENABLE_BIT = 0;
  // reset values
  localparam logic [7:0] MDSS_REG_RESET = 8'h00;
  localparam logic [2:0] MDSS_ADDR_HIGH_RESET = 3'h0;
  // data-space sizing
  localparam int MDSS_AUX_DEPTH = 2048;
  localparam int MDSS_AUX_AW = 11;
  localparam logic [15:0] MDSS_WINDOW_LAST = 16'h0800;
  // where a movx cycle goes
  typedef enum logic [1:0] {
    MDSS_TGT_NONE,
    MDSS_TGT_EXT,
    MDSS_TGT_AUX,
    MDSS_TGT_NVM
  } mdss_target_t;
  // one movx request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic dptr_mode;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mdss_movx_req_t;
  // one sfr access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mdss_sfr_req_t;
endpackage : mdss_pkg

//--- logic/mdss_top.sv
// movx data-space selector: sfr bits, aux sram, cycle steering
`timescale 1ns/1ps
`default_nettype none
module mdss_top import mdss_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // sfr port from the core
  input wire mdss_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // movx cycle from the core
  input wire mdss_movx_req_t i_movx,
  output logic [7:0] o_movx_rdata,
  output logic o_movx_rvalid,
  output logic o_movx_rdata_bad,
  // nvm side: flash data and sequencer status
  input wire logic [7:0] i_nvm_rdata,
  input wire logic i_nvm_busy,
  output logic o_nvm_rd,
  output logic [10:0] o_nvm_addr,
  // external data bus side
  output logic o_ext_rd,
  output logic o_ext_wr,
  output logic [15:0] o_ext_addr,
  output logic [7:0] o_ext_wdata,
  input wire logic [7:0] i_ext_rdata,
  // control bits for the nvm sequencer
  output logic [7:0] o_nvm_control,
  output logic [7:0] o_nvm_data_port,
  output logic [10:0] o_nvm_prog_addr
);
  ////////////////////////////////////////////////////////////////////
  // reset release
  // asserts at once, lets go two edges later, clear of the input edge
  logic [1:0] rst_sync_q; // release synchroniser
  logic rst_n; // synchronised reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////
  // special function registers
  logic [7:0] nvm_control_q; // erase/write requests, read enable
  logic [7:0] mem_mode_q; // memory mode, bit 0 aux enable
  logic [7:0] nvm_data_q; // data port for the sequencer
  logic [7:0] nvm_addr_low_q; // programming address low
  logic [2:0] nvm_addr_high_q; // programming address high, 3 bits
  logic nvm_read_enable; // steering bit
  logic aux_ram_enable; // steering bit

  // register writes; all cleared at reset
  // addresses outside the map fall through untouched
  // only three bits of the high programming address exist
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_control_q <= MDSS_REG_RESET; // RULE_15
      mem_mode_q <= MDSS_REG_RESET; // RULE_15
      nvm_data_q <= MDSS_REG_RESET;
      nvm_addr_low_q <= MDSS_REG_RESET;
      nvm_addr_high_q <= MDSS_ADDR_HIGH_RESET;
    end else if (i_sfr.wr) begin
      unique case (i_sfr.addr)
        MDSS_NVM_CONTROL_ADDR: nvm_control_q <= i_sfr.wdata;
        MDSS_MEMORY_MODE_ADDR: mem_mode_q <= i_sfr.wdata;
        MDSS_NVM_DATA_ADDR: nvm_data_q <= i_sfr.wdata;
        MDSS_NVM_ADDR_LOW_ADDR: nvm_addr_low_q <= i_sfr.wdata;
        MDSS_NVM_ADDR_HIGH_ADDR: nvm_addr_high_q <= i_sfr.wdata[2:0];
        default: ; // not ours
      endcase
    end
  end

  // field extraction
  // the two steering bits sit in different registers; software keeps
  // them consistent, the decode below gives the nvm bit priority
  assign nvm_read_enable = nvm_control_q[MDSS_NVM_READ_ENABLE_BIT]; // RULE_05
  assign aux_ram_enable = mem_mode_q[MDSS_AUX_RAM_ENABLE_BIT]; // RULE_05

  // sfr read mux, registered data
  // data holds until the next read strobe; missing bits read zero
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sfr_rdata <= MDSS_REG_RESET;
    end else if (i_sfr.rd) begin
      unique case (i_sfr.addr)
        MDSS_NVM_CONTROL_ADDR: o_sfr_rdata <= nvm_control_q;
        MDSS_MEMORY_MODE_ADDR: o_sfr_rdata <= mem_mode_q;
        MDSS_NVM_DATA_ADDR: o_sfr_rdata <= nvm_data_q;
        MDSS_NVM_ADDR_LOW_ADDR: o_sfr_rdata <= nvm_addr_low_q;
        MDSS_NVM_ADDR_HIGH_ADDR: o_sfr_rdata <= {5'h00, nvm_addr_high_q};
        default: o_sfr_rdata <= MDSS_REG_RESET;
      endcase
    end
  end

  // combinational hit flag for the core's sfr mux
  // address only, so the core can steer its read mux before the edge
  always_comb begin
    o_sfr_hit = (i_sfr.addr == MDSS_NVM_CONTROL_ADDR) ||
                (i_sfr.addr == MDSS_MEMORY_MODE_ADDR) ||
                (i_sfr.addr == MDSS_NVM_DATA_ADDR) ||
                (i_sfr.addr == MDSS_NVM_ADDR_LOW_ADDR) ||
                (i_sfr.addr == MDSS_NVM_ADDR_HIGH_ADDR);
  end

  // register contents out to the nvm sequencer
  assign o_nvm_control = nvm_control_q;
  assign o_nvm_data_port = nvm_data_q;
  assign o_nvm_prog_addr = {nvm_addr_high_q, nvm_addr_low_q};

  ////////////////////////////////////////////////////////////////////
  // cycle steering
  mdss_target_t target; // destination of the current cycle
  logic in_window; // address at or below 2K
  assign in_window = (i_movx.addr <= MDSS_WINDOW_LAST);

  // nvm enable wins over aux enable; the window edge is inclusive
  // nop outcomes raise no strobe and return no valid
  // decode; r0/r1 cycles only carry an 8-bit page offset, but the
  // core still presents the full 16-bit address here
  always_comb begin
    target = MDSS_TGT_NONE;
    if (i_movx.valid) begin
      if (nvm_read_enable) begin // RULE_09
        if (!i_movx.write) begin
          if (in_window) begin
            target = MDSS_TGT_NVM; // RULE_06 RULE_11 RULE_12
          end else if (i_movx.dptr_mode) begin
            target = MDSS_TGT_EXT; // RULE_11
          end else begin
            target = MDSS_TGT_NONE; // RULE_12
          end
        end else if (i_movx.dptr_mode && !in_window) begin
          target = MDSS_TGT_EXT; // RULE_13
        end else begin
          target = MDSS_TGT_NONE; // RULE_13 RULE_14
        end
      end else if (aux_ram_enable) begin
        target = MDSS_TGT_AUX; // RULE_03 RULE_08
      end else begin
        target = MDSS_TGT_EXT; // RULE_07
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // auxiliary sram, separate from the scratch-pad
  // no reset on the array: contents are unknown until written
  // indexed by the low eleven address bits, so 0x0800 aliases 0
  logic [7:0] aux_mem [MDSS_AUX_DEPTH]; // RULE_01 RULE_02
  logic [MDSS_AUX_AW-1:0] aux_addr; // low address bits
  assign aux_addr = i_movx.addr[MDSS_AUX_AW-1:0];

  // sram write port
  // written on the edge that takes the request, no read-back delay
  always_ff @(posedge i_clk) begin
    if (target == MDSS_TGT_AUX && i_movx.write) begin
      aux_mem[aux_addr] <= i_movx.wdata; // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////
  // strobes out to nvm and external bus
  // address and data pass straight through; only the strobes qualify
  // the nvm index shares the sram decode
  always_comb begin
    o_nvm_rd = (target == MDSS_TGT_NVM);
    o_nvm_addr = aux_addr; // RULE_06
    o_ext_rd = (target == MDSS_TGT_EXT) && !i_movx.write;
    o_ext_wr = (target == MDSS_TGT_EXT) && i_movx.write;
    o_ext_addr = i_movx.addr;
    o_ext_wdata = i_movx.wdata;
  end

  ////////////////////////////////////////////////////////////////////
  // read return, one cycle after the request
  // busy only matters while an erase or write is requested
  logic seq_active; // erase or write requested and sequencer busy
  assign seq_active = i_nvm_busy && (nvm_control_q[MDSS_NVM_ERASE_REQ_BIT] ||
                                     nvm_control_q[MDSS_NVM_WRITE_REQ_BIT]);

  // registered read data and flags; nop reads return zero and no valid
  // writes never raise a return pulse
  // the bad flag marks nvm data that software must discard
  // valid and bad default low each cycle, so they stand one cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_movx_rdata <= MDSS_REG_RESET;
      o_movx_rvalid <= 1'b0;
      o_movx_rdata_bad <= 1'b0;
    end else begin
      o_movx_rvalid <= 1'b0;
      o_movx_rdata_bad <= 1'b0;
      if (i_movx.valid && !i_movx.write) begin
        unique case (target)
          MDSS_TGT_AUX: begin
            o_movx_rdata <= aux_mem[aux_addr]; // RULE_08
            o_movx_rvalid <= 1'b1;
          end
          MDSS_TGT_NVM: begin
            o_movx_rdata <= i_nvm_rdata; // RULE_11
            o_movx_rvalid <= 1'b1;
            o_movx_rdata_bad <= seq_active; // RULE_10
          end
          MDSS_TGT_EXT: begin
            o_movx_rdata <= i_ext_rdata; // RULE_07
            o_movx_rvalid <= 1'b1;
          end
          MDSS_TGT_NONE: begin
            o_movx_rdata <= MDSS_REG_RESET; // RULE_12
          end
        endcase
      end
    end
  end
endmodule : mdss_top
`default_nettype wire
